// >>> hw/pmcr_top.v
// Power mode control and status register with mode sequencer.
//
// Decided for this implementation: the Wishbone register port and the address map.
`timescale 1ns/1ps
`include "pmcr_defines.vh"
module pmcr_top
(
    input wire SYS_CLK_I,
    input wire RESETN_I,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [3:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    output wire [31:0] WB_DAT_O,
    output wire WB_ACK_O,
    input wire CPU_WAIT_I,
    input wire WAKEUP_I,
    input wire HF_CLOCK_GOOD_I,
    input wire LF_CLOCK_GOOD_I,
    input wire SLOW_XTAL_SEL_I,
    output reg [1:0] MODE_O,
    output reg HF_OSC_EN_O,
    output reg SLOW_XTAL_SELECTED_O
);
    reg psr_r;
    reg hfd_r;
    reg idle_r;
    reg halt_r;
    reg wge_r;
    reg [1:0] mode_r;
    reg psr_nxt;
    reg hfd_nxt;
    reg idle_nxt;
    reg halt_nxt;
    reg wge_nxt;
    reg [1:0] mode_nxt;
    reg save_pend_r;
    reg save_pend_nxt;
    reg wake_pend_r;
    reg wake_pend_nxt;
    reg wait_d_r;
    reg exit_pend_r;
    reg exit_pend_nxt;
    reg wait_seen_r;
    reg wait_seen_nxt;
    wire hf_good;
    wire lf_good;
    wire xtal_good;
    wire wr_ctrl;
    wire [7:0] wr_data;
    wire [7:0] reg_view;
    reg [31:0] rd_data;
    wire wait_evt;

    pmcr_sync u_sync_hf
    (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RESETN_I),
        .async_i(HF_CLOCK_GOOD_I),
        .level_o(hf_good)
    );

    pmcr_sync u_sync_lf
    (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RESETN_I),
        .async_i(LF_CLOCK_GOOD_I),
        .level_o(lf_good)
    );

    pmcr_sync u_sync_xt
    (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RESETN_I),
        .async_i(SLOW_XTAL_SEL_I),
        .level_o(xtal_good)
    );

    pmcr_wb_slave u_wb
    (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RESETN_I),
        .cyc_i(WB_CYC_I),
        .stb_i(WB_STB_I),
        .we_i(WB_WE_I),
        .adr_i(WB_ADR_I),
        .sel_i(WB_SEL_I),
        .dat_i(WB_DAT_I),
        .rd_data_i(rd_data),
        .ack_o(WB_ACK_O),
        .dat_o(WB_DAT_O),
        .wr_ctrl_o(wr_ctrl),
        .wr_data_o(wr_data)
    );

    // Status bits come from hardware; bit 4 is always zero.
    assign reg_view = {lf_good, hf_good, wge_r, 1'b0, halt_r, idle_r, hfd_r, psr_r};

    // The status word exposes the sequencer's pending requests for debug.
    // Bit 4 is a software exit from Power Save that still waits for the fast clock.
    always @*
    begin
        case (WB_ADR_I)
            `PMCR_ADDR_CTRL: rd_data = {24'h0, reg_view};
            `PMCR_ADDR_STAT: rd_data = {27'h0, exit_pend_r, save_pend_r, wake_pend_r, mode_r};
            default: rd_data = 32'h0;
        endcase
    end

    // WAIT is a same-clock CPU signal; act on its rising edge only.
    assign wait_evt = CPU_WAIT_I & ~wait_d_r;

    // Entry from Active into a mode that runs from the slow clock waits for a good slow clock.
    // Halt uses no clock at all, so it is never held back.
    function entry_allowed;
        input [1:0] target;
        input lf_ok;
        begin
            case (target)
                `PMCR_MODE_SAVE: entry_allowed = lf_ok;
                `PMCR_MODE_IDLE: entry_allowed = lf_ok;
                default: entry_allowed = 1'b1;
            endcase
        end
    endfunction

    // The disable bit acts only once a Power Save or Idle stay has begun, never on the entry edge,
    // so the fast clock cannot vanish while the switch is still in progress.
    function fast_osc_on;
        input [1:0] cur_mode;
        input [1:0] next_mode;
        input disable_bit;
        begin
            case (next_mode)
                `PMCR_MODE_ACTIVE: fast_osc_on = 1'b1;
                `PMCR_MODE_HALT: fast_osc_on = 1'b0;
                default:
                begin
                    if (cur_mode != next_mode)
                        fast_osc_on = 1'b1;
                    else
                        fast_osc_on = ~disable_bit;
                end
            endcase
        end
    endfunction

    always @*
    begin
        psr_nxt = psr_r;
        hfd_nxt = hfd_r;
        idle_nxt = idle_r;
        halt_nxt = halt_r;
        wge_nxt = wge_r;
        mode_nxt = mode_r;
        save_pend_nxt = save_pend_r;
        wake_pend_nxt = wake_pend_r;
        exit_pend_nxt = exit_pend_r;
        wait_seen_nxt = wait_seen_r;
        if (wr_ctrl)
        begin
            // A write proves the CPU is running, so any held WAIT is over.
            wait_seen_nxt = 1'b0;
            hfd_nxt = wr_data[`PMCR_BIT_HFD];
            idle_nxt = wr_data[`PMCR_BIT_IDLE];
            halt_nxt = wr_data[`PMCR_BIT_HALT];
            wge_nxt = wr_data[`PMCR_BIT_WGE];
            if (wr_data[`PMCR_BIT_PSR] && mode_r == `PMCR_MODE_ACTIVE)
            begin
                if (wr_data[`PMCR_BIT_WGE])
                    psr_nxt = 1'b1;
                else
                    save_pend_nxt = 1'b1;
            end
            else if (!wr_data[`PMCR_BIT_PSR] && mode_r == `PMCR_MODE_SAVE)
            begin
                save_pend_nxt = 1'b0;
                exit_pend_nxt = 1'b1;
            end
            else if (wr_data[`PMCR_BIT_PSR] && mode_r == `PMCR_MODE_SAVE)
                exit_pend_nxt = 1'b0;
            else if (!wr_data[`PMCR_BIT_PSR])
                psr_nxt = 1'b0;
        end
        case (mode_r)
            `PMCR_MODE_ACTIVE:
            begin
                if (save_pend_r && entry_allowed(`PMCR_MODE_SAVE, lf_good))
                begin
                    mode_nxt = `PMCR_MODE_SAVE;
                    psr_nxt = 1'b1;
                    save_pend_nxt = 1'b0;
                end
                else if ((wait_evt || wait_seen_r) && wge_r)
                begin
                    // Direct entries from Active only when gated.
                    // A WAIT that meets a slow clock not yet good is kept until the clock is good.
                    wait_seen_nxt = 1'b0;
                    if (halt_r)
                        mode_nxt = `PMCR_MODE_HALT;
                    else if (idle_r)
                    begin
                        if (entry_allowed(`PMCR_MODE_IDLE, lf_good))
                            mode_nxt = `PMCR_MODE_IDLE;
                        else
                            wait_seen_nxt = 1'b1;
                    end
                    else if (psr_r)
                    begin
                        if (entry_allowed(`PMCR_MODE_SAVE, lf_good))
                            mode_nxt = `PMCR_MODE_SAVE;
                        else
                            wait_seen_nxt = 1'b1;
                    end
                end
            end
            `PMCR_MODE_SAVE:
            begin
                if (WAKEUP_I)
                    wake_pend_nxt = 1'b1;
                else if (wr_ctrl && !wr_data[`PMCR_BIT_PSR])
                    wake_pend_nxt = 1'b0;
                else if (wait_evt && halt_r)
                    mode_nxt = `PMCR_MODE_HALT;
                else if (wait_evt && idle_r)
                    mode_nxt = `PMCR_MODE_IDLE;
            end
            `PMCR_MODE_IDLE:
            begin
                if (WAKEUP_I)
                    wake_pend_nxt = 1'b1;
                else if (wait_evt && halt_r)
                    mode_nxt = `PMCR_MODE_HALT;
            end
            default:
            begin
                if (WAKEUP_I)
                    wake_pend_nxt = 1'b1;
            end
        endcase
        // Software exit from Power Save, done once the fast clock is good.
        if (mode_r == `PMCR_MODE_SAVE && !psr_nxt && !wake_pend_r && !save_pend_r && hf_good)
        begin
            if (!(wr_ctrl && wr_data[`PMCR_BIT_PSR]))
            begin
                mode_nxt = `PMCR_MODE_ACTIVE;
            end
        end
        // A software exit is remembered until the fast clock is good; the bit keeps reading 1 meanwhile.
        if (mode_r == `PMCR_MODE_SAVE && exit_pend_nxt)
        begin
            psr_nxt = 1'b1;
            save_pend_nxt = 1'b0;
            if (hf_good)
            begin
                mode_nxt = `PMCR_MODE_ACTIVE;
                psr_nxt = 1'b0;
                exit_pend_nxt = 1'b0;
            end
        end
        // Wake-up: drop the fast clock disable, then wait for a good clock.
        if (wake_pend_r || (WAKEUP_I && mode_r != `PMCR_MODE_ACTIVE))
        begin
            hfd_nxt = 1'b0;
            idle_nxt = 1'b0;
            halt_nxt = 1'b0;
            if (wake_pend_r && hf_good)
            begin
                mode_nxt = `PMCR_MODE_ACTIVE;
                psr_nxt = 1'b0;
                wake_pend_nxt = 1'b0;
                exit_pend_nxt = 1'b0;
                wait_seen_nxt = 1'b0;
            end
        end
    end

    always @(posedge SYS_CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            {wge_r, halt_r, idle_r, hfd_r, psr_r} <= 5'h00;
            mode_r <= `PMCR_MODE_ACTIVE;
            save_pend_r <= 1'b0;
            wake_pend_r <= 1'b0;
            wait_d_r <= 1'b0;
            exit_pend_r <= 1'b0;
            wait_seen_r <= 1'b0;
            MODE_O <= `PMCR_MODE_ACTIVE;
            HF_OSC_EN_O <= 1'b1;
            SLOW_XTAL_SELECTED_O <= 1'b0;
        end
        else
        begin
            psr_r <= psr_nxt;
            hfd_r <= hfd_nxt;
            idle_r <= idle_nxt;
            halt_r <= halt_nxt;
            wge_r <= wge_nxt;
            mode_r <= mode_nxt;
            save_pend_r <= save_pend_nxt;
            wake_pend_r <= wake_pend_nxt;
            wait_d_r <= CPU_WAIT_I;
            exit_pend_r <= exit_pend_nxt;
            wait_seen_r <= wait_seen_nxt;
            MODE_O <= mode_nxt;
            // Oscillator follows the mode being entered; it stops with entry into Halt, one cycle after entry into Power Save or Idle with the disable bit set.
            HF_OSC_EN_O <= fast_osc_on(mode_r, mode_nxt, hfd_nxt);
            SLOW_XTAL_SELECTED_O <= SLOW_XTAL_SEL_I ? xtal_good : 1'b0;
        end
    end
endmodule // pmcr_top

// >>> hw/pmcr_defines.vh
// Constants for the power mode control register block.
`ifndef PMCR_DEFINES_VH
`define PMCR_DEFINES_VH
`define PMCR_ADDR_CTRL 4'h0
`define PMCR_ADDR_STAT 4'h4
`define PMCR_BIT_PSR 0
`define PMCR_BIT_HFD 1
`define PMCR_BIT_IDLE 2
`define PMCR_BIT_HALT 3
`define PMCR_BIT_RSVD 4
`define PMCR_BIT_WGE 5
`define PMCR_BIT_HFG 6
`define PMCR_BIT_LFG 7
`define PMCR_CTRL_RESET 6'h00
`define PMCR_MODE_ACTIVE 2'h0
`define PMCR_MODE_SAVE 2'h1
`define PMCR_MODE_IDLE 2'h2
`define PMCR_MODE_HALT 2'h3
`endif

// >>> hw/pmcr_sync.v
// Three-stage synchroniser with agreement filter for asynchronous status inputs.
`timescale 1ns/1ps
module pmcr_sync
(
    input wire clk_i,
    input wire rst_n_i,
    input wire async_i,
    output reg level_o
);
    reg s1_r;
    reg s2_r;
    reg s3_r;

    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            level_o <= 1'b0;
        end
        else
        begin
            s1_r <= async_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // A change counts only once the last two stages agree.
            if (s2_r == s3_r)
                level_o <= s3_r;
        end
    end
endmodule // pmcr_sync

// >>> hw/pmcr_wb_slave.v
// Classic Wishbone slave front end with one-cycle acknowledge.
`timescale 1ns/1ps
`include "pmcr_defines.vh"
module pmcr_wb_slave
(
    input wire clk_i,
    input wire rst_n_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [3:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    input wire [31:0] rd_data_i,
    output reg ack_o,
    output reg [31:0] dat_o,
    output wire wr_ctrl_o,
    output wire [7:0] wr_data_o
);
    wire req;
    assign req = cyc_i & stb_i & ~ack_o;
    // Only the low byte lane holds register data.
    assign wr_ctrl_o = req & we_i & sel_i[0] & (adr_i == `PMCR_ADDR_CTRL);
    assign wr_data_o = dat_i[7:0];

    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end
        else
        begin
            ack_o <= req;
            dat_o <= (req & ~we_i) ? rd_data_i : 32'h0;
        end
    end
endmodule // pmcr_wb_slave

// >>> verification/pmcr_top_asserts.sv
// Port checker for the power mode control register block.
`timescale 1ns/1ps
module pmcr_top_asserts
(
    input wire SYS_CLK_I,
    input wire RESETN_I,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_ACK_O,
    input wire CPU_WAIT_I,
    input wire WAKEUP_I,
    input wire HF_CLOCK_GOOD_I,
    input wire LF_CLOCK_GOOD_I,
    input wire [1:0] MODE_O,
    input wire HF_OSC_EN_O
);
    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!RESETN_I);
    ack_time_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("ack late");
    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack too long");
    active_osc_a: assert property (MODE_O == 0 |-> HF_OSC_EN_O)
        else $error("osc off in Active");
    // Two cycles of grace, as the stop may trail the mode change.
    halt_osc_a: assert property ((MODE_O == 3 && !WAKEUP_I) [*3] |-> !HF_OSC_EN_O)
        else $error("osc on in Halt");
    hf_entry_a: assert property (MODE_O == 0 && $past(MODE_O) != 0 |-> $past(HF_CLOCK_GOOD_I, 2))
        else $error("Active without fast clock");
    lf_entry_a: assert property (MODE_O inside {1, 2} && $past(MODE_O) == 0 |-> $past(LF_CLOCK_GOOD_I, 2))
        else $error("slow mode without slow clock");
    wait_entry_a: assert property (MODE_O[1] && $past(MODE_O) != MODE_O |->
        $past(CPU_WAIT_I) || $past(CPU_WAIT_I, 2) || $past(CPU_WAIT_I, 3)) else $error("no WAIT");
    osc_wake_a: assert property ($rose(WAKEUP_I) && MODE_O != 0 |-> ##[1:4] HF_OSC_EN_O)
        else $error("osc not back on wake");
    cover property (MODE_O == 1);
    cover property (MODE_O == 2);
    cover property (MODE_O == 3);
endmodule // pmcr_top_asserts
bind pmcr_top pmcr_top_asserts u_asserts (.SYS_CLK_I(SYS_CLK_I), .RESETN_I(RESETN_I), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .CPU_WAIT_I(CPU_WAIT_I), .WAKEUP_I(WAKEUP_I),
    .HF_CLOCK_GOOD_I(HF_CLOCK_GOOD_I), .LF_CLOCK_GOOD_I(LF_CLOCK_GOOD_I), .MODE_O(MODE_O),
    .HF_OSC_EN_O(HF_OSC_EN_O));

// >>> verification/pmcr_cpu_model.sv
// CPU model that issues register cycles and WAIT pulses.
`timescale 1ns/1ps
module pmcr_cpu_model
(
    input wire clk_i,
    input wire ack_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [3:0] adr_o,
    output logic [31:0] dat_o,
    output logic wait_o
);
    initial {cyc_o, stb_o, we_o, adr_o, dat_o, wait_o} = '0;
    task xfer(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        {cyc_o, stb_o, we_o, adr_o, dat_o} <= {2'h3, w, a, 24'h0, d};
        do
            @(posedge clk_i);
        while (ack_i !== 1'b1);
        // Released lines change so that a late sample cannot pass.
        {cyc_o, stb_o, adr_o, dat_o} <= {2'h0, ~a, ~dat_o};
    endtask
    task pulse;
        @(posedge clk_i);
        wait_o <= 1'b1;
        @(posedge clk_i);
        wait_o <= 1'b0;
    endtask
endmodule // pmcr_cpu_model

// >>> verification/test_pmcr_top.sv
// Testbench for the power mode control register block.
`timescale 1ns/1ps
module test_pmcr_top;
    logic clk = 1'b0, rst_n = 1'b0, wk = 1'b0, hfg = 1'b1, lfg = 1'b1, xs = 1'b0;
    logic cyc, stb, we, wt, ack, hfe, xsel;
    logic [3:0] adr;
    logic [31:0] wd, rd;
    logic [1:0] mode;
    logic [7:0] r, e, m, eq[$], mq[$];
    int error_cnt = 0, comparisons = 0;
    always #25 clk = ~clk;
    pmcr_cpu_model cpu (.clk_i(clk), .ack_i(ack), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .dat_o(wd),
        .wait_o(wt));
    pmcr_top DUT (.SYS_CLK_I(clk), .RESETN_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(4'h1), .WB_DAT_I(wd), .WB_DAT_O(rd), .WB_ACK_O(ack), .CPU_WAIT_I(wt), .WAKEUP_I(wk),
        .HF_CLOCK_GOOD_I(hfg), .LF_CLOCK_GOOD_I(lfg), .SLOW_XTAL_SEL_I(xs), .MODE_O(mode), .HF_OSC_EN_O(hfe),
        .SLOW_XTAL_SELECTED_O(xsel));
    task chk(input string n, input logic [7:0] ex, input logic [7:0] g);
        comparisons++;
        if (g !== ex)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, ex, g);
        end
    endtask
    task close_out;
        if (error_cnt == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk)
        if (ack === 1'b1 && we === 1'b0)
        begin
            e = eq.pop_front();
            m = mq.pop_front();
            chk("rdata", e, rd[7:0] & m);
        end
    task rde(input logic [3:0] a, input logic [7:0] mk, input logic [7:0] ex);
        eq.push_back(ex & mk);
        mq.push_back(mk);
        cpu.xfer(1'b0, a, 8'h00);
    endtask
    task wr(input logic [7:0] d);
        cpu.xfer(1'b1, 4'h0, d);
    endtask
    task go(input logic [1:0] md);
        for (int n = 0; n < 30 && mode !== md; n++)
            @(negedge clk);
        chk("mode", {6'h0, md}, {6'h0, mode});
    endtask
    task stay(input logic [1:0] md);
        repeat (12) @(negedge clk);
        chk("mode", {6'h0, md}, {6'h0, mode});
    endtask
    task wake;
        @(posedge clk) wk <= 1'b1;
        go(2'h0);
        @(posedge clk) wk <= 1'b0;
        wr(8'h00);
    endtask
    initial
    begin
        r = $urandom(90556);
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        chk("osc", 8'h01, {7'h0, hfe});
        rde(4'h0, 8'hff, 8'hc0);
        rde(4'h8, 8'hff, 8'h00);
        repeat (4)
        begin
            r = $urandom & 8'hfe;
            wr(r);
            rde(4'h0, 8'hff, r & 8'h2e | 8'hc0);
        end
        chk("osc", 8'h01, {7'h0, hfe});
        wr(8'h21);
        rde(4'h0, 8'h01, 8'h01);
        stay(2'h0);
        cpu.pulse();
        go(2'h1);
        wr(8'h25);
        cpu.pulse();
        go(2'h2);
        wr(8'h2d);
        cpu.pulse();
        go(2'h3);
        stay(2'h3);
        chk("osc", 8'h00, {7'h0, hfe});
        wake();
        rde(4'h0, 8'h0c, 8'h00);
        @(posedge clk) lfg <= 1'b0;
        repeat (6) @(posedge clk);
        wr(8'h01);
        stay(2'h0);
        @(posedge clk) lfg <= 1'b1;
        go(2'h1);
        rde(4'h0, 8'h01, 8'h01);
        @(posedge clk) hfg <= 1'b0;
        repeat (6) @(posedge clk);
        wr(8'h00);
        stay(2'h1);
        rde(4'h0, 8'h01, 8'h01);
        @(posedge clk) hfg <= 1'b1;
        go(2'h0);
        rde(4'h0, 8'h01, 8'h00);
        wr(8'h04);
        cpu.pulse();
        stay(2'h0);
        wr(8'h24);
        cpu.pulse();
        go(2'h2);
        wake();
        @(posedge clk) lfg <= 1'b0;
        wr(8'h28);
        cpu.pulse();
        go(2'h3);
        wake();
        @(posedge clk) lfg <= 1'b1;
        wr(8'h23);
        stay(2'h0);
        chk("osc", 8'h01, {7'h0, hfe});
        cpu.pulse();
        go(2'h1);
        stay(2'h1);
        chk("osc", 8'h00, {7'h0, hfe});
        @(posedge clk) hfg <= 1'b0;
        repeat (6) @(posedge clk);
        wk <= 1'b1;
        stay(2'h1);
        chk("osc", 8'h01, {7'h0, hfe});
        @(posedge clk) hfg <= 1'b1;
        go(2'h0);
        @(posedge clk) wk <= 1'b0;
        rde(4'h0, 8'h02, 8'h00);
        @(posedge clk) xs <= 1'b1;
        repeat (8) @(negedge clk);
        chk("xtal", 8'h01, {7'h0, xsel});
        close_out();
    end
    initial
    begin
        #1000000;
        error_cnt++;
        close_out();
    end
endmodule // test_pmcr_top
